// ---- design/cspf_pkg.sv ----
package cspf_pkg;

  // Setpoint held as a count of 0.2 V steps above the 3.6 V floor
  localparam int unsigned SETPT_W       = 3;
  localparam logic [2:0]  SETPT_FLOOR   = 3'h0;  // 3.6 V
  localparam logic [2:0]  SETPT_CEIL    = 3'h7;  // 5.0 V
  localparam logic [2:0]  SETPT_STEP    = 3'h1;  // 0.2 V
  localparam logic [2:0]  SETPT_RESET   = 3'h7;  // 5.0 V after start-up

  // Clock
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Short timeout: 128 ms nominal
  localparam int unsigned SHORT_TIMEOUT_MS     = 128;
  localparam int unsigned SHORT_TIMEOUT_CYCLES = SHORT_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  // Pattern timeout default (not given numerically); plain default
  localparam int unsigned PATTERN_TIMEOUT_MS     = 100;
  localparam int unsigned PATTERN_TIMEOUT_CYCLES = PATTERN_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  // Pattern pulse timing: minimum and maximum high/low durations, in us
  localparam int unsigned PULSE_MIN_US     = 100;
  localparam int unsigned PULSE_MAX_US     = 1000;
  localparam int unsigned PULSE_MIN_CYCLES = (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_MAX_CYCLES = PULSE_MAX_US * 1000 / CLK_PERIOD_NS;
  // Long high pulse marks a step-up, short high pulse a step-down
  localparam int unsigned LONG_HIGH_US     = 500;
  localparam int unsigned LONG_HIGH_CYCLES = LONG_HIGH_US * 1000 / CLK_PERIOD_NS;
  // Pulses per complete pattern
  localparam int unsigned PATTERN_PULSES   = 3;

  // Width of the cycle counters
  localparam int unsigned CNT_W = 27;

  typedef enum logic [4:0] {
    CSPF_OFF     = 5'h01,  // Supply below cutoff, waiting for start threshold
    CSPF_RUN     = 5'h02,  // Switching
    CSPF_DISCH   = 5'h04,  // Latched fault, discharge to cutoff then restart
    CSPF_HICCUP  = 5'h08,  // Short hiccup, discharge and restart
    CSPF_HOT     = 5'h10   // Over-temperature stop
  } cspf_state_e;

endpackage

// ---- design/cspf_ctrl.sv ----
// Overview of operation
// - Step-down pattern lowers setpoint 0.2 V
// - Step-up pattern raises setpoint 0.2 V
// - Step-down ignored at 3.6 V floor
// - Long low pin returns setpoint to 5 V
// - Any protection event restores 5 V setpoint
// - Missing zero falling edge stops switching
// - Overvoltage shuts down, discharges to cutoff
// - Open feedback acts like overvoltage shutdown
// - After discharge, restart from start state
// - Low feedback for timeout declares short
// - Short causes hiccup until low feedback clears
// - Over-temperature stops switching immediately
// - Cooling before cutoff resumes, else hiccup
// - Short timeout is 128 ms nominal
// - Short threshold compared during hiccup too
`timescale 1ns/1ps
`default_nettype none

module cspf_ctrl
  import cspf_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES   = SHORT_TIMEOUT_CYCLES,
  parameter int unsigned PATTERN_CYCLES = PATTERN_TIMEOUT_CYCLES,
  parameter int unsigned PMIN_CYCLES    = PULSE_MIN_CYCLES,
  parameter int unsigned PMAX_CYCLES    = PULSE_MAX_CYCLES,
  parameter int unsigned PLONG_CYCLES   = LONG_HIGH_CYCLES
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 load_filter_high_i,    // Pin above pattern high level
  input  wire logic                 load_filter_low_i,     // Pin below filter_low_threshold
  input  wire logic                 sense_over_i,          // Winding sense above 7.5 V
  input  wire logic                 sense_short_i,         // Winding sense below short_sense_threshold
  input  wire logic                 sense_zero_edge_i,     // Falling edge to 0 V seen
  input  wire logic                 cycle_end_i,           // End of a switching cycle
  input  wire logic                 temp_over_i,           // Junction at 140 C
  input  wire logic                 temp_cool_i,           // Junction at or below 100 C
  input  wire logic                 supply_start_i,        // Supply above supply_start_threshold
  input  wire logic                 supply_low_i,          // Supply at supply_low_cutoff
  output logic                      switch_en_o,
  output logic                      internal_load_o,
  output logic [SETPT_W-1:0]        setpoint_o,
  output logic                      fault_o
);

  // Two-flop synchronisers on all analog comparator inputs
  // The first stage is read by the second stage only
  localparam int unsigned NSYNC = 10;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {load_filter_high_i, load_filter_low_i, sense_over_i, sense_short_i, sense_zero_edge_i,
                  cycle_end_i, temp_over_i, temp_cool_i, supply_start_i, supply_low_i};
      sync2_q <= sync1_q;
    end
  end

  // Synchronised comparator levels, in the order of the flop vector
  logic pin_high;
  logic pin_low;
  logic over;
  logic short_s;
  logic zero_edge;
  logic cyc_end;
  logic hot;
  logic cool;
  logic sup_start;
  logic sup_low;
  assign {pin_high, pin_low, over, short_s, zero_edge, cyc_end, hot, cool, sup_start, sup_low} = sync2_q;

  // Saturating counter step, shared by all duration counters
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Stopped fault states, shared by the load and fault outputs
  function automatic logic stopped_fault(input cspf_state_e s);
    stopped_fault = (s == CSPF_DISCH) || (s == CSPF_HICCUP) || (s == CSPF_HOT);
  endfunction

  cspf_state_e state_q;
  logic        running;
  assign running = (state_q == CSPF_RUN);

  // Zero-edge seen during the current switching cycle
  // Clear wins over a same-cycle edge, which no_edge already credits to the closing cycle
  logic edge_seen_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_seen_q <= 1'b0;
    end else if (!running || cyc_end) begin
      edge_seen_q <= 1'b0;
    end else if (zero_edge) begin
      edge_seen_q <= 1'b1;
    end
  end

  // A cycle that closes without its edge is a fault (continuous conduction or open feedback)
  logic no_edge;
  assign no_edge = running && cyc_end && !edge_seen_q && !zero_edge;

  // Short timer counts only while sense stays under threshold, in run or hiccup
  // Any sample above threshold restarts the count, so brief dips never trip it
  logic [CNT_W-1:0] short_cnt_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      short_cnt_q <= '0;
    end else if (!short_s || !(running || state_q == CSPF_HICCUP)) begin
      short_cnt_q <= '0;
    end else begin
      short_cnt_q <= sat_inc(short_cnt_q);
    end
  end
  logic short_hit;
  assign short_hit = running && (short_cnt_q >= CNT_W'(SHORT_CYCLES - 1));

  logic prot_event;
  assign prot_event = running && (over || no_edge || short_hit || hot);

  // Protection sequencing; supply must pass cutoff before any restart except the cool-down return from HOT to RUN
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= CSPF_OFF;
    end else begin
      case (state_q)
        CSPF_OFF: begin
          if (sup_start && !sup_low) begin
            state_q <= CSPF_RUN;
          end
        end
        CSPF_RUN: begin
          // Supply loss first: nothing can be sequenced once the supply is gone
          if (sup_low) begin
            state_q <= CSPF_OFF;
          end else if (over || no_edge) begin
            state_q <= CSPF_DISCH;
          end else if (short_hit) begin
            state_q <= CSPF_HICCUP;
          end else if (hot) begin
            state_q <= CSPF_HOT;
          end
        end
        CSPF_DISCH: begin
          if (sup_low) begin
            state_q <= CSPF_OFF;
          end
        end
        CSPF_HICCUP: begin
          // Restart from the cutoff; the timer decides again on the next start
          if (sup_low) begin
            state_q <= CSPF_OFF;
          end
        end
        CSPF_HOT: begin
          if (cool) begin
            state_q <= CSPF_RUN;
          end else if (sup_low) begin
            state_q <= CSPF_OFF;
          end
        end
        default: state_q <= CSPF_OFF;
      endcase
    end
  end

  // A restart while still hot passes through RUN for one cycle only:
  // prot_event gates switch_en_o in that cycle, so no switching pulse escapes,
  // and the state falls back to HOT until the junction has cooled

  // Pattern decoder: count high and low phase durations
  logic             pin_high_q;
  logic [CNT_W-1:0] phase_cnt_q;
  logic [1:0]       pulses_q;
  logic             pat_up_q;
  logic             pat_valid_q;
  logic             rise;
  logic             fall;
  assign rise = pin_high && !pin_high_q;
  assign fall = !pin_high && pin_high_q;

  // Delayed pin level; resets to the idle low level so no false edge follows reset
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_high_q <= 1'b0;
    end else begin
      pin_high_q <= pin_high;
    end
  end

  // Phase length, restarted on each pin edge; a count of n means n+1 cycles
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_cnt_q <= '0;
    end else if (rise || fall) begin
      phase_cnt_q <= '0;
    end else begin
      phase_cnt_q <= sat_inc(phase_cnt_q);
    end
  end

  logic dur_ok;
  logic dur_long;
  assign dur_ok   = (phase_cnt_q >= CNT_W'(PMIN_CYCLES)) && (phase_cnt_q <= CNT_W'(PMAX_CYCLES));
  assign dur_long = (phase_cnt_q >= CNT_W'(PLONG_CYCLES));

  // A pattern is PATTERN_PULSES high pulses of one kind, each within bounds
  logic pat_done_up;
  logic pat_done_dn;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulses_q    <= 2'h0;
      pat_up_q    <= 1'b0;
      pat_valid_q <= 1'b0;
    end else if (!running) begin
      pulses_q    <= 2'h0;
      pat_valid_q <= 1'b0;
    end else if (fall) begin
      if (!dur_ok || (pulses_q != 2'h0 && dur_long != pat_up_q)) begin
        pulses_q    <= 2'h0;
        pat_valid_q <= 1'b0;
      end else if (pulses_q == 2'(PATTERN_PULSES - 1)) begin
        pulses_q    <= 2'h0;
        pat_valid_q <= 1'b0;
      end else begin
        pulses_q    <= pulses_q + 2'h1;
        pat_up_q    <= dur_long;
        pat_valid_q <= 1'b1;
      end
    end else if (rise && !dur_ok && pulses_q != 2'h0) begin
      pulses_q    <= 2'h0; // Low gap out of bounds aborts
      pat_valid_q <= 1'b0;
    end
  end
  assign pat_done_up = running && fall && dur_ok && pat_valid_q && pat_up_q && dur_long
                       && (pulses_q == 2'(PATTERN_PULSES - 1));
  assign pat_done_dn = running && fall && dur_ok && pat_valid_q && !pat_up_q && !dur_long
                       && (pulses_q == 2'(PATTERN_PULSES - 1));

  // Pattern timeout: pin held below low threshold
  logic [CNT_W-1:0] low_cnt_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_cnt_q <= '0;
    end else if (!pin_low) begin
      low_cnt_q <= '0;
    end else begin
      low_cnt_q <= sat_inc(low_cnt_q);
    end
  end
  logic timeout_hit;
  assign timeout_hit = (low_cnt_q > CNT_W'(PATTERN_CYCLES));

  // Setpoint; protection wins over any pattern in the same cycle, timeout only while below 5 V
  // In HOT the setpoint was already forced to 5 V on entry, so it is left alone
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      setpoint_o <= SETPT_RESET;
    end else if (!running && state_q != CSPF_HOT) begin
      setpoint_o <= SETPT_CEIL; // Fresh start-up always at 5 V
    end else if (prot_event) begin
      setpoint_o <= SETPT_CEIL;
    end else if (timeout_hit && setpoint_o != SETPT_CEIL) begin
      setpoint_o <= SETPT_CEIL;
    end else if (pat_done_dn && setpoint_o != SETPT_FLOOR) begin
      setpoint_o <= setpoint_o - SETPT_STEP;
    end else if (pat_done_up && setpoint_o != SETPT_CEIL) begin
      setpoint_o <= setpoint_o + SETPT_STEP;
    end
  end

  // Switching enable; drops at the same edge at which the state leaves RUN
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      switch_en_o <= 1'b0;
    end else begin
      switch_en_o <= running && !prot_event && !sup_low;
    end
  end

  // Internal circuitry kept on to bleed the supply in every stopped fault state
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      internal_load_o <= 1'b0;
    end else begin
      internal_load_o <= (running && prot_event) || stopped_fault(state_q);
    end
  end

  // Fault flag follows the same stop condition as the internal load
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= (running && prot_event) || stopped_fault(state_q);
    end
  end

endmodule

`default_nettype wire

// ---- verification/cspf_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module cspf_assertions
  import cspf_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES = 50
) (
  input wire logic               core_clk_i,
  input wire logic               reset_n_i,
  input wire logic               sense_over_i,
  input wire logic               sense_short_i,
  input wire logic               temp_over_i,
  input wire logic               supply_low_i,
  input wire logic               switch_en_o,
  input wire logic               internal_load_o,
  input wire logic [SETPT_W-1:0] setpoint_o,
  input wire logic               fault_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Run of low-sense cycles, saturating so it never wraps
  int unsigned short_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      short_q <= 0;
    end else if (!sense_short_i) begin
      short_q <= 0;
    end else if (short_q < SHORT_CYCLES + 8) begin
      short_q <= short_q + 1;
    end
  end
  step_one_a: assert property ($changed(setpoint_o) && setpoint_o != SETPT_CEIL |-> switch_en_o &&
    (setpoint_o == $past(setpoint_o) + 3'h1 || setpoint_o == $past(setpoint_o) - 3'h1))
    else $error("setpoint jumped");
  ceil_on_fault_a: assert property ($rose(fault_o) |-> ##[0:2] setpoint_o == SETPT_CEIL)
    else $error("setpoint not restored");
  fault_stops_a: assert property (fault_o |-> !switch_en_o)
    else $error("switching during fault");
  load_stops_a: assert property (internal_load_o |-> !switch_en_o)
    else $error("switching while discharging");
  over_stop_a: assert property ($rose(sense_over_i) && switch_en_o && !supply_low_i
    |-> ##[1:4] (!switch_en_o && internal_load_o)) else $error("no overvoltage stop");
  hot_stop_a: assert property (temp_over_i |-> ##[1:4] !switch_en_o)
    else $error("no thermal stop");
  low_off_a: assert property (supply_low_i |-> ##[1:4] (!switch_en_o && !internal_load_o && !fault_o))
    else $error("no return to off");
  short_trip_a: assert property (short_q == SHORT_CYCLES + 6 |-> !switch_en_o)
    else $error("short not declared");
endmodule
bind cspf_ctrl cspf_assertions #(.SHORT_CYCLES(SHORT_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sense_over_i(sense_over_i),
  .sense_short_i(sense_short_i), .temp_over_i(temp_over_i), .supply_low_i(supply_low_i),
  .switch_en_o(switch_en_o), .internal_load_o(internal_load_o), .setpoint_o(setpoint_o), .fault_o(fault_o));
`default_nettype wire

// ---- verification/cspf_handset.sv ----
`timescale 1ns/1ps
`default_nettype none
module cspf_handset (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic up_i,
  input  wire logic drop_i,
  output logic      high_o,
  output logic      low_o,
  output logic      busy_o
);
  // Three pulses; long highs ask up, short highs ask down
  initial begin
    {high_o, busy_o} = 2'b00;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        repeat (3) begin
          high_o <= 1'b1;
          repeat (up_i ? 20 : 8) @(posedge clk_i);
          high_o <= 1'b0;
          repeat (8) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
  // Pin sits low only while the handset drops its load
  assign low_o = drop_i & ~high_o;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cspf_pkg::*;
  logic clk, rst_n, hi, lo, ovr, sht, zed, cend, hot, cool, st, low, go, up, drop, busy, en, sw, ld, flt;
  logic [SETPT_W-1:0] sp;
  integer seed = 90219, err_total = 0, total_checks = 0, msp = 7, i;
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Random cycle ends, never two in a row
  always @(posedge clk) cend <= en && !cend && (($random(seed) & 7) == 0);
  cspf_handset hs (.clk_i(clk), .go_i(go), .up_i(up), .drop_i(drop), .high_o(hi), .low_o(lo), .busy_o(busy));
  cspf_ctrl #(.SHORT_CYCLES(50), .PATTERN_CYCLES(40), .PMIN_CYCLES(4), .PMAX_CYCLES(30), .PLONG_CYCLES(15)) dut (
    .core_clk_i(clk), .reset_n_i(rst_n), .load_filter_high_i(hi), .load_filter_low_i(lo),
    .sense_over_i(ovr), .sense_short_i(sht), .sense_zero_edge_i(zed), .cycle_end_i(cend),
    .temp_over_i(hot), .temp_cool_i(cool), .supply_start_i(st), .supply_low_i(low),
    .switch_en_o(sw), .internal_load_o(ld), .setpoint_o(sp), .fault_o(flt));
  task automatic tk(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(string nm, logic [2:0] s, logic [2:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One pattern; model steps once, clamped at both ends
  task automatic pat(logic u);
    up <= u;
    go <= 1'b1;
    tk(1);
    go <= 1'b0;
    tk(2);
    for (i = 0; busy && i < 300; i++) tk(1);
    if (busy) begin
      err_total++;
      results();
    end
    tk(6);
    if (u && msp < 7) msp++;
    if (!u && msp > 0) msp--;
    chk("sp", sp, 3'(msp));
  endtask
  // Supply sags to cutoff, then restarts
  task automatic recycle();
    low <= 1'b1;
    tk(6);
    chk("off", {sw, ld, flt}, 3'b000);
    low <= 1'b0;
    tk(8);
    chk("run", {sw, ld, flt}, 3'b100);
  endtask
  initial begin
    {rst_n, ovr, sht, hot, st, low, go, up, drop, en} = '0;
    {zed, cool} = 2'b11;
    tk(4);
    rst_n <= 1'b1;
    chk("rst", {sw, ld, flt}, 3'b000);
    chk("rst_sp", sp, 3'(msp));
    st <= 1'b1;
    en <= 1'b1;
    tk(8);
    chk("run", {sw, ld, flt}, 3'b100);
    pat(1'b1);
    for (int j = 0; j < 8; j++) pat(1'b0);
    pat(1'b1);
    $display("test steps done");
    drop <= 1'b1;
    tk(30);
    chk("wdog_early", sp, 3'(msp));
    tk(20);
    drop <= 1'b0;
    msp = 7;
    tk(6);
    chk("wdog", sp, 3'(msp));
    pat(1'b0);
    {hot, cool} <= 2'b10;
    msp = 7;
    tk(6);
    chk("hot", {1'b0, sw, flt}, 3'b001);
    chk("sp", sp, 3'(msp));
    low <= 1'b1;
    tk(6);
    chk("hotoff", {sw, ld, flt}, 3'b000);
    low <= 1'b0;
    tk(8);
    chk("hotrun", {sw, ld, flt}, 3'b011);
    {hot, cool} <= 2'b01;
    tk(8);
    chk("cool", {1'b0, sw, flt}, 3'b010);
    $display("test thermal done");
    sht <= 1'b1;
    tk(40);
    chk("early", {sw, ld, flt}, 3'b100);
    tk(20);
    chk("short", {1'b0, sw, flt}, 3'b001);
    sht <= 1'b0;
    recycle();
    $display("test short done");
    pat(1'b0);
    ovr <= 1'b1;
    msp = 7;
    tk(6);
    chk("over", {sw, ld, flt}, 3'b011);
    chk("sp", sp, 3'(msp));
    ovr <= 1'b0;
    recycle();
    zed <= 1'b0;
    for (i = 0; !ld && i < 300; i++) tk(1);
    if (!ld) begin
      err_total++;
      results();
    end
    tk(2);
    chk("noedge", {sw, ld, flt}, 3'b011);
    zed <= 1'b1;
    recycle();
    $display("test guards done");
    results();
  end
endmodule
`default_nettype wire
